// ==== logic/clock_stretch_relocate_reset.v ====
// Master clock generator for the processor chip set: normal, relocation
// and chip-reset cycles, plus the power-up double reset.
// Assumes every input but clk and resetn arrives from pins outside the system clock domain.
`timescale 1ns/1ps
`include "clock_stretch_defines.vh"

module clock_stretch_relocate_reset (
    input  wire        clk,                        // 200 MHz system clock.
    input  wire        resetn,                     // Synchronous reset, low.
    input  wire        power_good,                 // Supply good, async.
    input  wire        mmu_present,                // Relocation chip strap.
    input  wire        relocate_request_n,         // Relocation request, low.
    input  wire        control_error,              // Bad control chip select.
    input  wire        bus_error,                  // Nonexistent memory.
    input  wire        parity_error,               // Read parity error.
    input  wire        reloc_abort,                // Mapped reference abort.
    input  wire [21:0] chip_addr_data_bus,         // Chip bus address.
    output reg         mclk,                       // Master clock to chips.
    output reg         relocate_clock_hold,        // Relocation hold.
    output reg         address_latch_strobe,       // Address capture pulse.
    output reg  [21:0] system_bus_addr_data_lines, // System bus address.
    output reg         reset_stretch,              // Reset stretch enable.
    output reg         chip_reset,                 // Initialising reset.
    output reg  [8:0]  trap_vector                 // Vector of last reset.
);

    // ****************************************************************
    // Local constants
    // ****************************************************************

    localparam ST_INIT = 2'd0;  // Held high waiting for power good.
    localparam ST_HIGH = 2'd1;  // Clock-high phase.
    localparam ST_LOW  = 2'd2;  // Clock-low phase.

    localparam CY_NORMAL = 2'd0;  // Plain low phase.
    localparam CY_RELOC  = 2'd1;  // Relocation stretched low phase.
    localparam CY_RESET  = 2'd2;  // Chip reset stretched low phase.

    localparam SYNC_W = 29;  // Width of the bundled pin synchroniser.

    // Raw counts from the defines as plain integers; each is then cut
    // on purpose to the width of the counter that compares against it.
    localparam integer HF_LAST_I    = `HF_CYCLES - 1;
    localparam integer HIGH_LAST_I  = `HIGH_PERIODS - 1;
    localparam integer NORM_LAST_I  = `NORMAL_LOW_PERIODS - 1;
    localparam integer RST_LAST_I   = `RESET_LOW_PERIODS - 1;
    localparam integer REL_LAST_I   = `RELOC_LOW_PERIODS - 1;
    localparam integer HOLD_AT_I    = `HOLD_START_PERIODS;
    localparam integer STROBE_AT_I  = `STROBE_PERIODS;
    localparam integer PWR_RESETS_I = `POWERUP_RESETS;

    localparam [3:0] HF_LAST    = HF_LAST_I[3:0];
    localparam [2:0] HIGH_LAST  = HIGH_LAST_I[2:0];
    localparam [2:0] NORM_LAST  = NORM_LAST_I[2:0];
    localparam [2:0] RST_LAST   = RST_LAST_I[2:0];
    localparam [2:0] REL_LAST   = REL_LAST_I[2:0];
    localparam [2:0] HOLD_AT    = HOLD_AT_I[2:0];
    localparam [2:0] STROBE_AT  = STROBE_AT_I[2:0];
    localparam [1:0] PWR_RESETS = PWR_RESETS_I[1:0];

    // ****************************************************************
    // Declarations
    // ****************************************************************

    reg  [SYNC_W-1:0] sync_a;        // First synchroniser stage.
    reg  [SYNC_W-1:0] sync_b;        // Second synchroniser stage.
    wire [SYNC_W-1:0] pins;          // Raw pin bundle.

    wire        pg_s;                // Synchronised power good.
    wire        mmu_s;               // Synchronised strap.
    wire        req_s;               // Synchronised request, active high.
    wire [3:0]  err_s;               // Synchronised error conditions.
    wire [21:0] bus_s;               // Synchronised chip bus.

    reg  [1:0]  state;               // Clock phase state.
    reg  [1:0]  cycle;               // Kind of the current low phase.
    reg  [3:0]  sub_cnt;             // System clocks inside a period.
    reg  [2:0]  per_cnt;             // Periods inside the phase.
    reg  [3:0]  pending;             // Latched error conditions.
    reg  [1:0]  pwr_left;            // Power-up resets still owed.
    reg         mmu_fitted;          // Strap caught while initialising.

    wire        hf_tick;             // Last system clock of a period.
    reg  [2:0]  low_last;            // Final period index of this low.
    wire        phase_end;           // Current phase finishes now.
    reg  [8:0]  next_vector;         // Vector for a reset cycle.
    reg  [3:0]  clr_mask;            // Error bit served by the reset.
    wire        take_reset;          // Next low phase is a reset cycle.
    wire [21:0] addr_view;           // Address as seen by the bus.

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************

    assign pins = {power_good, mmu_present, ~relocate_request_n,
                   control_error, bus_error, parity_error, reloc_abort,
                   chip_addr_data_bus};

    // Two stages for every pin; only the second stage is read.
    // The chip bus is sampled bit by bit, so a reply must stand for two
    // clocks before the capture edge; the relocation chip's reply does.
    always @(posedge clk) begin
        if (!resetn) begin
            sync_a <= {SYNC_W{1'b0}};
            sync_b <= {SYNC_W{1'b0}};
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end

    assign pg_s  = sync_b[28];
    assign mmu_s = sync_b[27];
    assign req_s = sync_b[26];
    assign err_s = sync_b[25:22];
    assign bus_s = sync_b[21:0];

    // ****************************************************************
    // Phase timing
    // ****************************************************************

    assign hf_tick = (sub_cnt == HF_LAST);

    // Length of the present low phase by cycle kind.
    always @* begin
        case (cycle)
            CY_RELOC: low_last = REL_LAST;
            CY_RESET: low_last = RST_LAST;
            default:  low_last = NORM_LAST;
        endcase
    end

    assign phase_end = hf_tick &&
                       (((state == ST_HIGH) && (per_cnt == HIGH_LAST)) ||
                        ((state == ST_LOW) && (per_cnt == low_last)));

    // A reset cycle wins over relocation; errors need attention first.
    assign take_reset = (pwr_left != 2'd0) || (pending != 4'h0);

    // Vector choice; power-up resets first, then control error has the highest precedence.
    always @* begin
        next_vector = `VEC_NONE;
        clr_mask    = 4'h0;
        if (pwr_left != 2'd0) begin
            next_vector = `VEC_NONE;
        end else if (pending[3]) begin
            next_vector = `VEC_CONTROL_ERR;
            clr_mask    = 4'h8;
        end else if (pending[2]) begin
            next_vector = `VEC_BUS_ERR;
            clr_mask    = 4'h4;
        end else if (pending[1]) begin
            next_vector = `VEC_PARITY_ERR;
            clr_mask    = 4'h2;
        end else if (pending[0]) begin
            next_vector = `VEC_RELOC_ABORT;
            clr_mask    = 4'h1;
        end
    end

    // ****************************************************************
    // Clock state machine
    // ****************************************************************

    // Counts periods, picks the kind of each low phase and drives mclk.
    always @(posedge clk) begin
        if (!resetn) begin
            state       <= ST_INIT;
            cycle       <= CY_NORMAL;
            sub_cnt     <= 4'h0;
            per_cnt     <= 3'h0;
            mclk        <= 1'b1;
            pwr_left    <= 2'd0;
            mmu_fitted  <= 1'b0;
            trap_vector <= `VEC_NONE;
        end else begin
            sub_cnt <= hf_tick ? 4'h0 : sub_cnt + 4'h1;
            if (hf_tick && !phase_end) begin
                per_cnt <= per_cnt + 3'h1;
            end
            case (state)
                ST_INIT: begin
                    // Clock held high until the supply is good.
                    mclk       <= 1'b1;
                    sub_cnt    <= 4'h0;
                    per_cnt    <= 3'h0;
                    mmu_fitted <= mmu_s;
                    if (pg_s) begin
                        pwr_left    <= PWR_RESETS - 2'd1;
                        cycle       <= CY_RESET;
                        trap_vector <= `VEC_NONE;
                        state       <= ST_LOW;
                        mclk        <= 1'b0;
                    end
                end
                ST_HIGH: begin
                    if (phase_end) begin
                        per_cnt <= 3'h0;
                        state   <= ST_LOW;
                        mclk    <= 1'b0;
                        if (take_reset) begin
                            cycle       <= CY_RESET;
                            trap_vector <= next_vector;
                            if (pwr_left != 2'd0) begin
                                pwr_left <= pwr_left - 2'd1;
                            end
                        // Request seen at end of high.
                        end else if (req_s && mmu_fitted) begin
                            cycle <= CY_RELOC;
                        end else begin
                            cycle <= CY_NORMAL;
                        end
                    end
                end
                ST_LOW: begin
                    // Clock rises once the count completes.
                    if (phase_end) begin
                        per_cnt <= 3'h0;
                        state   <= ST_HIGH;
                        mclk    <= 1'b1;
                        cycle   <= CY_NORMAL;
                    end
                end
                default: begin
                    state <= ST_INIT;
                    mclk  <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Error latches
    // ****************************************************************

    // A new error in the cycle it is served stays latched: set wins.
    always @(posedge clk) begin
        if (!resetn) begin
            pending <= 4'h0;
        end else if ((state == ST_HIGH) && phase_end &&
                     (pwr_left == 2'd0)) begin
            pending <= (pending & ~clr_mask) | err_s;
        end else begin
            pending <= pending | err_s;
        end
    end

    // ****************************************************************
    // Relocation hold, reset stretch and address capture
    // ****************************************************************

    // Upper bits forced low without a relocation chip.
    assign addr_view = mmu_fitted ? bus_s
                     : {6'h00, bus_s[`VIRT_ADDR_W-1:0]};

    // Hold and reset rise one period into low and fall with the phase.
    // They are registered so the chips never see a decode glitch, with
    // no lag: the decode uses the last system clock of the period, hf_tick.
    always @(posedge clk) begin
        if (!resetn) begin
            relocate_clock_hold        <= 1'b0;
            reset_stretch              <= 1'b0;
            chip_reset                 <= 1'b0;
            address_latch_strobe       <= 1'b0;
            system_bus_addr_data_lines <= 22'h000000;
        end else begin
            address_latch_strobe <= 1'b0;
            if ((state != ST_LOW) || phase_end) begin
                relocate_clock_hold <= 1'b0;
                reset_stretch       <= 1'b0;
                chip_reset          <= 1'b0;
            end else if (hf_tick && (per_cnt == HOLD_AT - 3'h1)) begin
                relocate_clock_hold <= (cycle == CY_RELOC);
                reset_stretch       <= (cycle == CY_RESET);
                chip_reset          <= (cycle == CY_RESET);
            end
            if ((state == ST_LOW) && (cycle == CY_RELOC) && hf_tick &&
                (per_cnt == STROBE_AT - 3'h1)) begin
                address_latch_strobe <= 1'b1;
                system_bus_addr_data_lines <= addr_view;
            end else if ((state == ST_HIGH) && phase_end && !take_reset &&
                         !(req_s && mmu_fitted)) begin
                // Unrelocated address goes out as the low phase begins.
                address_latch_strobe       <= 1'b1;
                system_bus_addr_data_lines <= addr_view;
            end
        end
    end

endmodule // clock_stretch_relocate_reset

// ==== logic/clock_stretch_defines.vh ====
// Constants for the master clock stretcher with relocation and chip reset.
// Assumes a 200 MHz system clock from which the 65 ns reference is derived.
`ifndef CLOCK_STRETCH_DEFINES_VH
`define CLOCK_STRETCH_DEFINES_VH

// System clock period and reference period, in ns.
`define CLK_PERIOD_NS      5
`define HF_PERIOD_NS       65
// System clocks per reference period, rounded up.
`define HF_CYCLES          ((`HF_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Phase lengths, in reference periods; the relocation low is first given in ns.
`define HIGH_PERIODS       2
`define NORMAL_LOW_PERIODS 2
`define RESET_LOW_PERIODS  3
`define RELOC_LOW_NS       325
`define RELOC_LOW_PERIODS  (`RELOC_LOW_NS / `HF_PERIOD_NS)

// Event points inside the low phase.
`define HOLD_START_NS      65
`define HOLD_START_PERIODS (`HOLD_START_NS / `HF_PERIOD_NS)
`define STROBE_NS          195
`define STROBE_PERIODS     (`STROBE_NS / `HF_PERIOD_NS)

// Number of chip resets forced at power-up.
`define POWERUP_RESETS     2

// Trap vectors, octal 10, 4, 114 and 250.
`define VEC_CONTROL_ERR    9'h008
`define VEC_BUS_ERR        9'h004
`define VEC_PARITY_ERR     9'h04c
`define VEC_RELOC_ABORT    9'h0a8
`define VEC_NONE           9'h000

// Address widths.
`define PHYS_ADDR_W        22
`define VIRT_ADDR_W        16

`endif

// ==== verif/clock_stretch_monitor.sv ====
// Port checker for the master clock stretcher: phase lengths, events.
// Assumes one clk domain and a reference period of 13 clocks.
`timescale 1ns/1ps
module clock_stretch_monitor (
    input wire        clk,                        // System clock.
    input wire        resetn,                     // Reset, active low.
    input wire        mclk,                       // Master clock.
    input wire        relocate_clock_hold,        // Relocation hold.
    input wire        address_latch_strobe,       // Capture pulse.
    input wire [21:0] system_bus_addr_data_lines, // System bus lines.
    input wire        reset_stretch,              // Stretch enable.
    input wire        chip_reset                  // Initialising reset.
);
    // ********************************
    // Clock phases and stretch events
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_high_span: assert property (
        $rose(mclk) |-> ##25 mclk ##1 !mclk) else $error("High span wrong.");
    chk_low_span: assert property (
        $fell(mclk) |-> ##25 !mclk ##[1:40] mclk)
        else $error("Low span wrong.");
    chk_hold_start: assert property (
        $rose(relocate_clock_hold) |-> $past(mclk, 14) && !$past(mclk, 13))
        else $error("Hold rose at the wrong time.");
    chk_hold_span: assert property (
        $rose(relocate_clock_hold) |-> ##51 (relocate_clock_hold && !mclk)
        ##1 (mclk && !relocate_clock_hold)) else $error("Hold span wrong.");
    chk_strobe_time: assert property (
        $rose(relocate_clock_hold) |-> ##26 address_latch_strobe)
        else $error("Strobe missing.");
    chk_strobe_pulse: assert property (
        address_latch_strobe |=> !address_latch_strobe)
        else $error("Strobe too long.");
    chk_bus_follows: assert property (
        !$stable(system_bus_addr_data_lines) |-> address_latch_strobe)
        else $error("Bus changed without strobe.");
    chk_reset_start: assert property (
        $rose(reset_stretch) |-> chip_reset && !$past(mclk, 13)
        && $past(mclk, 14)) else $error("Reset stretch start wrong.");
    chk_reset_span: assert property (
        $rose(reset_stretch) |-> ##25 (!mclk && chip_reset) ##1
        (mclk && !reset_stretch && !chip_reset))
        else $error("Reset span wrong.");
    chk_no_overlap: assert property (
        !(relocate_clock_hold && reset_stretch))
        else $error("Hold during reset cycle.");
endmodule // clock_stretch_monitor

// ==== verif/reloc_chip_model.sv ====
// Behavioural relocation chip on the far side of the stretcher.
// Assumes the bench drives pick, lag and next_addr at falling edges.
`timescale 1ns/1ps
module reloc_chip_model (
    input  wire         clk,                 // System clock.
    input  wire         mclk,                // Master clock.
    input  wire         relocate_clock_hold, // Hold from the block.
    input  wire         pick,                // Relocate next cycle.
    input  wire  [3:0]  lag,                 // Answer delay, clocks.
    input  wire  [21:0] next_addr,           // Next physical address.
    output wire         relocate_request_n,  // Request, active low.
    output wire  [21:0] chip_addr_data_bus   // Shared chip bus.
);
    // **************************
    // Request and address reply
    // **************************
    int          hc = 0;     // Clocks into the high phase.
    int          cnt = 0;    // Clocks into the hold.
    logic        go = 0;     // This cycle relocates.
    logic [3:0]  lag_q = 0;  // Delay held for this answer.
    logic [21:0] addr = 0;   // Address to return.
    logic        req_n_q = 1'b1;  // Request register, idle high.
    logic [21:0] bus_q = 22'h0;   // Chip bus register.
    assign relocate_request_n = req_n_q;
    assign chip_addr_data_bus = bus_q;
    // Lag varies so both prompt and slow answers are seen.
    always @(negedge clk) begin
        hc <= mclk ? hc + 1 : 0;
        if (!mclk) go <= pick;
        req_n_q <= !(go && mclk && hc >= 18);
        if (relocate_clock_hold) begin
            cnt <= cnt + 1;
            if (cnt == lag_q) begin
                bus_q <= addr;
                clock_stretch_relocate_reset_tb.exp_addr.push_back(addr);
            end
        end else begin
            cnt <= 0;
            lag_q <= lag;
            addr <= next_addr;
            // A released bus must not keep a stale value.
            bus_q <= ~bus_q;
        end
    end
endmodule // reloc_chip_model

// ==== verif/clock_stretch_relocate_reset_tb.sv ====
// Self-checking bench for the master clock stretcher.
// Assumes the checker and relocation chip model compile first.
`timescale 1ns/1ps
`include "clock_stretch_defines.vh"
module clock_stretch_relocate_reset_tb;
    // ***********************
    // Stimulus and scoreboard
    // ***********************
    logic        clk = 0;         // System clock.
    logic        resetn = 0;      // Reset, active low.
    logic        power_good = 0;  // Supply good.
    logic        mmu_present = 1; // Relocation chip strap.
    logic [3:0]  err = 0;         // Control, bus, parity, abort.
    logic        pick = 0;        // Random relocate choice.
    logic [3:0]  lag = 0;         // Random answer delay.
    logic [21:0] next_addr = 0;   // Random physical address.
    wire         mclk, hold, strobe, stretch, chip_reset, req_n;
    wire  [21:0] bus_lines, chip_bus;
    wire  [8:0]  trap_vector;
    logic [8:0]  exp_vec[$];      // Expected vectors, oldest first.
    logic [21:0] exp_addr[$];     // Expected relocated addresses.
    logic [8:0]  vecs[4] = '{`VEC_CONTROL_ERR, `VEC_BUS_ERR,
                             `VEC_PARITY_ERR, `VEC_RELOC_ABORT};
    logic [8:0]  e_vec;
    logic [21:0] e_addr;
    logic        was_rst = 0;     // Chip reset one clock ago.
    int          err_total = 0;
    int          compares = 0;
    int          seed = 54;
    int          r;
    always #2.5 clk = ~clk;
    clock_stretch_relocate_reset DUT (.clk(clk), .resetn(resetn),
        .power_good(power_good), .mmu_present(mmu_present),
        .relocate_request_n(req_n), .control_error(err[0]),
        .bus_error(err[1]), .parity_error(err[2]), .reloc_abort(err[3]),
        .chip_addr_data_bus(chip_bus), .mclk(mclk),
        .relocate_clock_hold(hold), .address_latch_strobe(strobe),
        .system_bus_addr_data_lines(bus_lines), .reset_stretch(stretch),
        .chip_reset(chip_reset), .trap_vector(trap_vector));
    reloc_chip_model mmu (.clk(clk), .mclk(mclk),
        .relocate_clock_hold(hold), .pick(pick), .lag(lag),
        .next_addr(next_addr), .relocate_request_n(req_n),
        .chip_addr_data_bus(chip_bus));
    // Random choices reach the block through the model.
    always @(negedge clk) begin
        r = $random(seed);
        pick <= r[0];
        lag <= r[4:1];
        next_addr <= r[31:10];
    end
    task automatic note(input logic ok, input logic [21:0] got, exp);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_vec(input logic [8:0] got, exp);
        note(got === exp, {13'h0, got}, {13'h0, exp});
    endtask
    task automatic check_addr(input logic [21:0] got, exp);
        note(got === exp, got, exp);
    endtask
    // Results are taken at falling edges, once they have settled.
    always @(negedge clk) begin
        if (resetn && was_rst && !chip_reset) begin
            e_vec = (exp_vec.size() > 0) ? exp_vec.pop_front() : 9'h1ff;
            check_vec(trap_vector, e_vec);
        end
        if (resetn && strobe && hold) begin
            e_addr = (exp_addr.size() > 0) ? exp_addr.pop_front() : 22'h3fffff;
            check_addr(bus_lines, e_addr);
        end
        if (resetn && strobe && !mmu_present)
            check_addr({bus_lines[21:16], 16'h0}, 22'h0);
        was_rst <= chip_reset;
    end
    task automatic drain;
        for (int i = 0; i < 800 && exp_vec.size() > 0; i++) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // The run needs about 4500 clocks; 20000 means a hang.
    initial begin
        #100000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        exp_vec = '{9'h0, 9'h0};
        repeat (2) @(negedge clk);
        resetn = 1;
        repeat (10) @(negedge clk);
        power_good = 1;
        drain;
        repeat (2000) @(negedge clk);
        // Each error alone, then all four together in priority order.
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            err = (i < 4) ? 4'(1 << i) : 4'hf;
            for (int k = 0; k < 4; k++)
                if (i == k || i == 4) exp_vec.push_back(vecs[k]);
            @(negedge clk);
            err = 4'h0;
            drain;
        end
        // Strap absent: requests are refused and bus stays in 64 KB.
        @(negedge clk);
        resetn = 0;
        mmu_present = 0;
        @(negedge clk);
        exp_addr.delete();
        exp_vec = '{9'h0, 9'h0};
        repeat (2) @(negedge clk);
        resetn = 1;
        drain;
        repeat (1500) @(negedge clk);
        check_addr(22'(exp_vec.size() + exp_addr.size()), 22'h0);
        tally_and_finish;
    end
endmodule // clock_stretch_relocate_reset_tb
bind clock_stretch_relocate_reset clock_stretch_monitor u_mon (
    .clk(clk), .resetn(resetn), .mclk(mclk),
    .relocate_clock_hold(relocate_clock_hold),
    .address_latch_strobe(address_latch_strobe),
    .system_bus_addr_data_lines(system_bus_addr_data_lines),
    .reset_stretch(reset_stretch), .chip_reset(chip_reset));
